// >>> hw/stp_params.svh
// Purpose: offsets, field positions and reset values of the test pattern block
// Assumes: 4-bit register address, 16-bit register data
// Notes: included by the generator, the property module and the bench
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

// register offsets
`define STP_REG_CTRL 4'h0
`define STP_REG_LANE 4'h1
`define STP_REG_CUSTOM 4'h2
`define STP_REG_STATUS 4'h3

// control register fields
`define STP_CTRL_GSEL_LSB 0
`define STP_CTRL_GSEL_MSB 2
`define STP_CTRL_IND 3
`define STP_CTRL_GPRBS 4
`define STP_CTRL_PSEUDO_RANDOM_ENABLE 5
`define STP_CTRL_PRBS_LONG 6
`define STP_CTRL_PRBS_RST 7
`define STP_CTRL_SER_LSB 8
`define STP_CTRL_SER_MSB 9
`define STP_CTRL_JESD 10
`define STP_CTRL_FSEL_LSB 11
`define STP_CTRL_FSEL_MSB 13
`define STP_CTRL_FPRBS 14

// lane register fields: 3-bit selects from bit 0, prbs enables from bit 12
`define STP_LANE_PRBS_LSB 12

// status register fields
`define STP_STAT_OVF 0
`define STP_STAT_FULL 1
`define STP_STAT_VALID 2

// reset values
`define STP_CTRL_RESET 16'h0200
`define STP_LANE_RESET 16'h0000
`define STP_CUSTOM_RESET 16'h0000
`define STP_PRBS_SEED 23'h7fffff

// lane count
`define STP_LANES 4
`endif

// >>> hw/stp_pattern_gen.sv
// Purpose: substitutes test patterns for lane result words and the frame word
// Assumes: conversion clock and trigger arrive as asynchronous pins
// Notes: words are MSB-aligned in 16 bits; bits below the factor read zero except in the normal lane pattern
`include "stp_params.svh"

module stp_pattern_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regReadData,
    // pins
    input wire logic conversionClock,
    input wire logic transmitTriggerPin,
    // channel result words, lane 0 in the low bits
    input wire logic [63:0] channelResultWords,
    // serializer side
    output logic [63:0] serialDataLanes,
    output logic [15:0] frameClockWord,
    output logic wordValid,
    input wire logic wordReady,
    output logic jesdEnable
);
    localparam int LANES = `STP_LANES;
    localparam int BUFW = 16 * LANES + 16;

    logic [15:0] ctrl_q;
    logic [15:0] laneCfg_q;
    logic [15:0] custom_q;
    logic [15:0] readData_q;
    logic overflow_q;
    logic [1:0] convSync_q;
    logic [1:0] trigSync_q;
    logic convPrev_q;
    logic trigPrev_q;
    logic prbsRstPrev_q;
    logic pending_q;
    logic [15:0] ramp_q;
    logic toggle_q;
    logic [22:0] prbs_q;
    logic jesd_q;
    stp_pkg::stp_gen_state_t genState_q;
    logic convEdge;
    logic restart;
    logic accept;
    logic bufReady;
    logic bufFull;
    logic bufValid;
    logic [BUFW-1:0] bufOut;
    logic [BUFW-1:0] bufIn;
    logic [15:0] prbsWord;
    logic [22:0] prbsNext;
    logic [15:0] frameWord;
    logic [2:0] gsel;
    logic [2:0] fsel;
    logic [1:0] ser;

    assign gsel = ctrl_q[`STP_CTRL_GSEL_MSB:`STP_CTRL_GSEL_LSB];
    assign fsel = ctrl_q[`STP_CTRL_FSEL_MSB:`STP_CTRL_FSEL_LSB];
    assign ser = ctrl_q[`STP_CTRL_SER_MSB:`STP_CTRL_SER_LSB];

    // mask keeping the active number of bits, MSB side
    function automatic logic [15:0] serMask(input logic [1:0] f);
        case (stp_pkg::stp_factor_t'(f))
            stp_pkg::STP_SER_10: serMask = 16'hffc0;
            stp_pkg::STP_SER_12: serMask = 16'hfff0;
            stp_pkg::STP_SER_14: serMask = 16'hfffc;
            default: serMask = 16'hffff;
        endcase
    endfunction

    // upper half of the active bits set
    function automatic logic [15:0] syncWord(input logic [1:0] f);
        case (stp_pkg::stp_factor_t'(f))
            stp_pkg::STP_SER_10: syncWord = 16'hf800;
            stp_pkg::STP_SER_12: syncWord = 16'hfc00;
            stp_pkg::STP_SER_14: syncWord = 16'hfe00;
            default: syncWord = 16'hff00;
        endcase
    endfunction

    // ramp count lifted to the MSB side
    function automatic logic [15:0] rampWord(input logic [15:0] r, input logic [1:0] f);
        case (stp_pkg::stp_factor_t'(f))
            stp_pkg::STP_SER_10: rampWord = {r[9:0], 6'h00};
            stp_pkg::STP_SER_12: rampWord = {r[11:0], 4'h0};
            stp_pkg::STP_SER_14: rampWord = {r[13:0], 2'h0};
            default: rampWord = r;
        endcase
    endfunction

    // pattern word for one select code; normal passes through
    function automatic logic [15:0] patWord(
        input logic [2:0] code,
        input logic usePrbs,
        input logic [15:0] normal,
        input logic [1:0] f,
        input logic [15:0] cust,
        input logic [15:0] ramp,
        input logic tog,
        input logic [15:0] prb
    );
        logic [15:0] w;
        w = 16'h0000;
        case (stp_pkg::stp_pattern_t'(code))
            stp_pkg::STP_PAT_NORMAL: w = normal;
            stp_pkg::STP_PAT_ZEROS: w = 16'h0000;
            stp_pkg::STP_PAT_ONES: w = 16'hffff;
            stp_pkg::STP_PAT_DESKEW: w = 16'h5555;
            stp_pkg::STP_PAT_SYNC: w = syncWord(f);
            stp_pkg::STP_PAT_CUSTOM: w = usePrbs ? prb : cust;
            stp_pkg::STP_PAT_RAMP: w = usePrbs ? prb : rampWord(ramp, f);
            stp_pkg::STP_PAT_TOGGLE: w = tog ? 16'hffff : 16'h0000;
            default: w = normal;
        endcase
        patWord = (code == stp_pkg::STP_PAT_NORMAL) ? w : (w & serMask(f));
    endfunction

    // sixteen generator steps; emitted bits form the word MSB first
    function automatic logic [38:0] prbsStep(input logic [22:0] s, input logic longSeq);
        logic [22:0] st;
        logic [15:0] bits;
        logic fb;
        st = s;
        bits = 16'h0000;
        fb = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (longSeq) begin
                bits[15-i] = st[22];
                fb = st[22] ^ st[17];
                st = {st[21:0], fb};
            end else begin
                bits[15-i] = st[8];
                fb = st[8] ^ st[4];
                st = {14'h0000, st[7:0], fb};
            end
        end
        prbsStep = {st, bits};
    endfunction

    assign {prbsNext, prbsWord} = prbsStep(prbs_q, ctrl_q[`STP_CTRL_PRBS_LONG]);

    // pins pass two flops before any logic reads them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convSync_q <= 2'b00;
            trigSync_q <= 2'b00;
            convPrev_q <= 1'b0;
            trigPrev_q <= 1'b0;
        end else begin
            convSync_q <= {convSync_q[0], conversionClock};
            trigSync_q <= {trigSync_q[0], transmitTriggerPin};
            convPrev_q <= convSync_q[1];
            trigPrev_q <= trigSync_q[1];
        end
    end

    // bit restart fires on the clear after a set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prbsRstPrev_q <= 1'b0;
        end else begin
            prbsRstPrev_q <= ctrl_q[`STP_CTRL_PRBS_RST];
        end
    end

    assign convEdge = convSync_q[1] && !convPrev_q;
    assign restart = (trigSync_q[1] && !trigPrev_q) ||
        (prbsRstPrev_q && !ctrl_q[`STP_CTRL_PRBS_RST]);
    assign accept = pending_q && bufReady;

    // one word owed per conversion edge, held until the buffer takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (convEdge) begin
            pending_q <= 1'b1;
        end else if (accept) begin
            pending_q <= 1'b0;
        end
    end

    // a restart parks the generators at their start until the next word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            genState_q <= stp_pkg::STP_GEN_RUN;
        end else begin
            case (genState_q)
                stp_pkg::STP_GEN_RUN: genState_q <= restart ?
                    stp_pkg::STP_GEN_RESTART : stp_pkg::STP_GEN_RUN;
                stp_pkg::STP_GEN_RESTART: genState_q <= stp_pkg::STP_GEN_WAIT;
                stp_pkg::STP_GEN_WAIT: genState_q <= (accept && !restart) ?
                    stp_pkg::STP_GEN_RUN : genState_q;
                default: genState_q <= stp_pkg::STP_GEN_RUN;
            endcase
        end
    end

    // generators step only on words taken, so a stall keeps the sequence whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_q <= 16'h0000;
            toggle_q <= 1'b0;
            prbs_q <= `STP_PRBS_SEED;
        end else if (restart || (genState_q == stp_pkg::STP_GEN_RESTART && !accept)) begin
            ramp_q <= 16'h0000;
            toggle_q <= 1'b0;
            prbs_q <= `STP_PRBS_SEED;
        end else if (accept) begin
            ramp_q <= ramp_q + 16'h0001;
            toggle_q <= !toggle_q;
            prbs_q <= prbsNext;
        end
    end

    // per-lane substitution at the result stage
    generate
        for (genvar g = 0; g < LANES; g++) begin : gLane
            logic [2:0] code;
            logic usePrbs;
            // per-lane fields win only while individual select is on
            assign code = ctrl_q[`STP_CTRL_IND] ? laneCfg_q[3*g+2:3*g] : gsel;
            assign usePrbs = ctrl_q[`STP_CTRL_PSEUDO_RANDOM_ENABLE] && (ctrl_q[`STP_CTRL_IND] ?
                laneCfg_q[`STP_LANE_PRBS_LSB+g] : ctrl_q[`STP_CTRL_GPRBS]);
            // jesd transport uses this same word, so no separate path
            assign bufIn[16*g+15:16*g] = patWord(code, usePrbs,
                channelResultWords[16*g+15:16*g], ser, custom_q, ramp_q,
                toggle_q, prbsWord);
        end
    endgenerate

    // frame word: normal is the half-high frame shape
    assign frameWord = patWord(fsel,
        ctrl_q[`STP_CTRL_FPRBS] && ctrl_q[`STP_CTRL_PSEUDO_RANDOM_ENABLE],
        syncWord(ser), ser, custom_q, ramp_q, toggle_q, prbsWord);
    assign bufIn[BUFW-1:BUFW-16] = frameWord;

    stp_skid_buffer #(
        .WIDTH(BUFW)
    ) uBuffer (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(pending_q),
        .inReady(bufReady),
        .inData(bufIn),
        .outValid(bufValid),
        .outReady(wordReady),
        .outData(bufOut),
        .full(bufFull)
    );

    assign serialDataLanes = bufOut[16*LANES-1:0];
    assign frameClockWord = bufOut[BUFW-1:BUFW-16];
    assign wordValid = bufValid;
    assign jesdEnable = jesd_q;

    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `STP_CTRL_RESET;
            laneCfg_q <= `STP_LANE_RESET;
            custom_q <= `STP_CUSTOM_RESET;
        end else if (regWrite) begin
            case (regAddr)
                `STP_REG_CTRL: ctrl_q <= {1'b0, regWriteData[14:0]};
                `STP_REG_LANE: laneCfg_q <= regWriteData;
                `STP_REG_CUSTOM: custom_q <= regWriteData;
                default: ;
            endcase
        end
    end

    // registered copy so the output comes from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            jesd_q <= 1'b0;
        end else begin
            jesd_q <= ctrl_q[`STP_CTRL_JESD];
        end
    end

    // lost word: an edge while the previous one is still owed; set beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_q <= 1'b0;
        end else if (convEdge && pending_q && !bufReady) begin
            overflow_q <= 1'b1;
        end else if (regWrite && regAddr == `STP_REG_STATUS &&
            regWriteData[`STP_STAT_OVF]) begin
            overflow_q <= 1'b0;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData_q <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                `STP_REG_CTRL: readData_q <= ctrl_q;
                `STP_REG_LANE: readData_q <= laneCfg_q;
                `STP_REG_CUSTOM: readData_q <= custom_q;
                `STP_REG_STATUS: readData_q <= {13'h0000, bufValid, bufFull, overflow_q};
                default: readData_q <= 16'h0000;
            endcase
        end else begin
            readData_q <= 16'h0000;
        end
    end

    assign regReadData = readData_q;
endmodule

// >>> hw/stp_pkg.sv
// Purpose: types of the test pattern block
// Assumes: nothing
// Notes: pattern codes are shared by global, lane and frame selects
package stp_pkg;
    typedef enum logic [2:0] {
        STP_PAT_NORMAL = 3'b000,
        STP_PAT_ZEROS = 3'b001,
        STP_PAT_ONES = 3'b010,
        STP_PAT_DESKEW = 3'b011,
        STP_PAT_SYNC = 3'b100,
        STP_PAT_CUSTOM = 3'b101,
        STP_PAT_RAMP = 3'b110,
        STP_PAT_TOGGLE = 3'b111
    } stp_pattern_t;

    typedef enum logic [1:0] {
        STP_SER_10 = 2'b00,
        STP_SER_12 = 2'b01,
        STP_SER_14 = 2'b10,
        STP_SER_16 = 2'b11
    } stp_factor_t;

    typedef enum logic [1:0] {
        STP_GEN_RUN = 2'b00,
        STP_GEN_WAIT = 2'b01,
        STP_GEN_RESTART = 2'b10
    } stp_gen_state_t;
endpackage

// >>> hw/stp_skid_buffer.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: output data and valid come straight from the head flops
module stp_skid_buffer #(
    parameter int WIDTH = 80
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // state
    output logic full
);
    logic headValid_q;
    logic spareValid_q;
    logic [WIDTH-1:0] head_q;
    logic [WIDTH-1:0] spare_q;

    // only refuse when the spare entry is taken, so a stall never drops a word
    assign inReady = !spareValid_q;
    assign outValid = headValid_q;
    assign outData = head_q;
    assign full = spareValid_q;

    // head refills from spare first to keep order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            headValid_q <= 1'b0;
            head_q <= '0;
        end else if (outReady || !headValid_q) begin
            if (spareValid_q) begin
                head_q <= spare_q;
                headValid_q <= 1'b1;
            end else begin
                headValid_q <= inValid;
                if (inValid) begin
                    head_q <= inData;
                end
            end
        end
    end

    // spare catches a word while the head is stalled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spareValid_q <= 1'b0;
            spare_q <= '0;
        end else if (outReady || !headValid_q) begin
            spareValid_q <= 1'b0;
        end else if (inValid && !spareValid_q) begin
            spare_q <= inData;
            spareValid_q <= 1'b1;
        end
    end
endmodule

// >>> verif/stp_pattern_gen_props.sv
// Purpose: port-level checks of the test pattern generator
// Assumes: control writes happen only while no words sit in the buffer
// Notes: a mirror of control writes tells which pattern is in force
`include "stp_params.svh"
module stp_pattern_gen_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regReadData,
    // stream
    input wire logic [63:0] serialDataLanes,
    input wire logic [15:0] frameClockWord,
    input wire logic wordValid,
    input wire logic wordReady,
    input wire logic jesdEnable
);
    logic [15:0] ctrlQ;
    logic [15:0] maskW;
    logic [15:0] syncW;
    logic isGlobal;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // mirror of the control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ <= `STP_CTRL_RESET;
        end else if (regWrite && regAddr == `STP_REG_CTRL) begin
            ctrlQ <= regWriteData;
        end
    end
    // top N ones and the sync word for the factor in force
    assign maskW = 16'hffff << (6 - 2 * ctrlQ[9:8]);
    assign syncW = ~(16'hffff >> (5 + ctrlQ[9:8]));
    assign isGlobal = wordValid && !ctrlQ[3];
    sequence s_held;
        wordValid && !wordReady;
    endsequence
    sequence s_ctrl_read;
        regRead && regAddr == `STP_REG_CTRL;
    endsequence
    property p_stay;
        s_held |=> wordValid && $stable(serialDataLanes) && $stable(frameClockWord);
    endproperty
    a_stay: assert property (p_stay) else $error("word changed while stalled");
    property p_rd_idle;
        !regRead |=> regReadData == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
    property p_unmapped;
        regRead && regAddr > `STP_REG_STATUS |=> regReadData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_rd;
        s_ctrl_read |=> regReadData == {1'b0, ctrlQ[14:0]};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_jesd;
        regWrite && regAddr == `STP_REG_CTRL |=> ##1 jesdEnable == $past(regWriteData[10], 2);
    endproperty
    a_jesd: assert property (p_jesd) else $error("jesd enable not mirrored");
    property p_ones;
        isGlobal && ctrlQ[2:0] == stp_pkg::STP_PAT_ONES |-> serialDataLanes == {4{maskW}};
    endproperty
    a_ones: assert property (p_ones) else $error("ones word wrong");
    property p_deskew;
        isGlobal && ctrlQ[2:0] == stp_pkg::STP_PAT_DESKEW
            |-> serialDataLanes == {4{16'h5555 & maskW}};
    endproperty
    a_deskew: assert property (p_deskew) else $error("deskew word wrong");
    property p_sync;
        isGlobal && ctrlQ[2:0] == stp_pkg::STP_PAT_SYNC |-> serialDataLanes == {4{syncW}};
    endproperty
    a_sync: assert property (p_sync) else $error("sync word wrong");
    property p_frame;
        wordValid && ctrlQ[13:11] == stp_pkg::STP_PAT_NORMAL |-> frameClockWord == syncW;
    endproperty
    a_frame: assert property (p_frame) else $error("normal frame word wrong");
endmodule

// >>> verif/stp_rx_model.sv
// Purpose: receiver that takes words off the stream
// Assumes: mode 0 always ready, 1 random stalls, 2 stalled
// Notes: reports each accepted word for one cycle
module stp_rx_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // stream
    input wire logic wordValid,
    output logic wordReady,
    input wire logic [63:0] serialDataLanes,
    input wire logic [15:0] frameClockWord,
    // bench side
    input wire logic [1:0] stallMode,
    output logic gotWord,
    output logic [63:0] gotLanes,
    output logic [15:0] gotFrame
);
    // ready moves only after an edge, and a stall may come at any time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wordReady <= 1'b0;
        end else begin
            wordReady <= stallMode == 2'd0 || (stallMode == 2'd1 && $urandom_range(1) == 1);
        end
    end
    // capture on handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gotWord <= 1'b0;
            gotLanes <= '0;
            gotFrame <= '0;
        end else begin
            gotWord <= wordValid && wordReady;
            if (wordValid && wordReady) begin
                gotLanes <= serialDataLanes;
                gotFrame <= frameClockWord;
            end
        end
    end
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the test pattern generator
// Assumes: config changes only while the stream is idle
// Notes: pseudo-random words come from a bench model of the sequence
`include "stp_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWriteData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regReadData;
    logic conversionClock = 1'b0;
    logic transmitTriggerPin = 1'b0;
    logic [63:0] channelResultWords = 64'h0;
    logic [63:0] serialDataLanes;
    logic [15:0] frameClockWord;
    logic wordValid;
    logic wordReady;
    logic jesdEnable;
    logic [1:0] stallMode = 2'd0;
    logic gotWord;
    logic [63:0] gotLanes;
    logic [15:0] gotFrame;
    logic convRun = 1'b0;
    logic [2:0] laneCode [4];
    logic [2:0] frameCode;
    logic [1:0] factor = 2'd2;
    logic [15:0] custom = 16'h0000;
    logic [15:0] rdq;
    logic [3:0] ra [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
    logic [15:0] rv [5] = '{`STP_CTRL_RESET, 16'h0, 16'h0, 16'h0, 16'h0};
    int idx;
    logic [22:0] prb = '1;
    logic [15:0] pw;
    logic [4:0] pOn = 5'h00;
    logic [3:0] laneEn = 4'h0;
    logic prbsEn = 1'b0;
    logic gPrbs = 1'b0;
    logic fPrbs = 1'b0;
    logic lng = 1'b1;
    logic [2:0] convCnt = 3'd0;
    int failures;
    int checks;
    always #50 clk = ~clk;
    // conversion clock of 800 ns, held low between runs
    always @(posedge clk) begin
        convCnt <= convRun ? convCnt + 3'd1 : 3'd0;
        conversionClock <= convRun && convCnt[2];
    end
    stp_pattern_gen i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .conversionClock(conversionClock),
        .transmitTriggerPin(transmitTriggerPin), .channelResultWords(channelResultWords),
        .serialDataLanes(serialDataLanes), .frameClockWord(frameClockWord),
        .wordValid(wordValid), .wordReady(wordReady), .jesdEnable(jesdEnable));
    stp_rx_model i_rx (.clk(clk), .rst_n(rst_n), .wordValid(wordValid), .wordReady(wordReady),
        .serialDataLanes(serialDataLanes), .frameClockWord(frameClockWord),
        .stallMode(stallMode), .gotWord(gotWord), .gotLanes(gotLanes), .gotFrame(gotFrame));
    // expected word of a code at the current word index
    function automatic logic [15:0] expWord(logic [2:0] c, logic [15:0] nrm, logic p);
        logic [15:0] m;
        m = 16'hffff << (6 - 2 * factor);
        case (c)
            3'h0: return nrm;
            3'h1: return 16'h0000;
            3'h2: return m;
            3'h3: return 16'h5555 & m;
            3'h4: return ~(16'hffff >> (5 + factor));
            3'h5: return (p ? pw : custom) & m;
            3'h6: return p ? pw & m : 16'(idx << (6 - 2 * factor));
            default: return idx[0] ? m : 16'h0000;
        endcase
    endfunction
    // next sixteen sequence bits, first one out in the MSB
    function automatic logic [15:0] prbsWord(logic l);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            if (l) begin
                w[i] = prb[22];
                prb = {prb[21:0], prb[22] ^ prb[17]};
            end else begin
                w[i] = prb[8];
                prb[8:0] = {prb[7:0], prb[8] ^ prb[4]};
            end
        end
        return w;
    endfunction
    task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rdq = regReadData;
    endtask
    // configure, optionally restart by the control bit, then stream n words
    task automatic run(int n, logic [2:0] gsel, logic ind, logic [2:0] fsel, logic rst);
        logic [15:0] c;
        c = {1'b0, fPrbs, fsel, 1'($urandom), factor, rst, lng, prbsEn, gPrbs, ind, gsel};
        frameCode = fsel;
        for (int g = 0; g < 4; g++) begin
            if (!ind) laneCode[g] = gsel;
            pOn[g] = prbsEn && (ind ? laneEn[g] : gPrbs);
        end
        pOn[4] = prbsEn && fPrbs;
        wr(`STP_REG_CTRL, c);
        wr(`STP_REG_CTRL, c & 16'hff7f);
        idx = 0;
        prb = '1;
        convRun <= 1'b1;
        repeat (n * 8) @(posedge clk);
        convRun <= 1'b0;
        repeat (40) @(posedge clk);
        chk("word count", 1, idx >= n - 1);
        $display("test code %0d factor %0d words %0d done", gsel, factor, idx);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // every accepted word against the configured patterns
    always @(posedge clk) begin
        if (gotWord === 1'b1) begin
            pw = prbsWord(lng);
            for (int g = 0; g < 4; g++) begin
                chk("lane", expWord(laneCode[g], channelResultWords[16*g +: 16], pOn[g]),
                    gotLanes[16*g +: 16]);
            end
            chk("frame", expWord(frameCode, ~(16'hffff >> (5 + factor)), pOn[4]),
                gotFrame);
            idx++;
        end
    end
    initial begin
        #1_000_000;
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hf6d7));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset value", rv[i], rdq);
        end
        custom = 16'($urandom);
        wr(`STP_REG_CUSTOM, custom);
        rd(`STP_REG_CUSTOM);
        chk("custom", custom, rdq);
        $display("test registers done");
        stallMode <= 2'd1;
        for (int c = 0; c < 8; c++) begin
            factor = 2'(c);
            channelResultWords <= {$urandom, $urandom};
            run(6, 3'(c), 1'b0, 3'(c), 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            factor = 2'($urandom);
            prbsEn = (k == 1);
            lng = (k != 1);
            laneEn = 4'($urandom) | 4'h1;
            for (int g = 0; g < 4; g++) laneCode[g] = 3'($urandom);
            laneCode[0] = 3'h6;
            wr(`STP_REG_LANE, {laneEn, laneCode[3], laneCode[2], laneCode[1], laneCode[0]});
            run(5, 3'h0, 1'b1, 3'h0, 1'b1);
        end
        // global pseudo-random on lanes and frame, enable off again after
        prbsEn = 1'b1;
        gPrbs = 1'b1;
        fPrbs = 1'b1;
        lng = 1'b1;
        run(6, 3'h5, 1'b0, 3'h6, 1'b1);
        prbsEn = 1'b0;
        factor = 2'd3;
        run(4, 3'h6, 1'b0, 3'h7, 1'b1);
        @(posedge clk);
        transmitTriggerPin <= 1'b1;
        repeat (4) @(posedge clk);
        transmitTriggerPin <= 1'b0;
        repeat (10) @(posedge clk);
        run(4, 3'h6, 1'b0, 3'h7, 1'b0);
        stallMode <= 2'd2;
        convRun <= 1'b1;
        repeat (40) @(posedge clk);
        convRun <= 1'b0;
        repeat (10) @(posedge clk);
        rd(`STP_REG_STATUS);
        chk("status full", 16'h0007, rdq);
        wr(`STP_REG_STATUS, 16'h0001);
        rd(`STP_REG_STATUS);
        chk("status cleared", 16'h0006, rdq);
        stallMode <= 2'd0;
        repeat (20) @(posedge clk);
        $display("test overflow done");
        wrap_up();
    end
endmodule
bind stp_pattern_gen stp_pattern_gen_props i_props (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .serialDataLanes(serialDataLanes),
    .frameClockWord(frameClockWord), .wordValid(wordValid), .wordReady(wordReady),
    .jesdEnable(jesdEnable));
